// file: rtl/sfc_pkg.sv
// Shared constants for the serial FIFO transmit control block.
// Assumes a 40 MHz peripheral clock and plain-port control bits.
package sfc_pkg;
    localparam int FIFO_DEPTH = 16;
    localparam int COUNT_W = 5;
    localparam int CHAR_W = 9;
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic [4:0] COUNT_FULL = 5'h10;
    localparam logic [3:0] BIT_RESET = 4'h0;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam int BAUD_DIV_DEFAULT = 16;
    localparam logic [CHAR_W-1:0] DATA_RESET = 9'h000;
endpackage

// file: rtl/tx_word_if.sv
// Word stream carrier between the FIFO and the serialiser.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface tx_word_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// file: rtl/tx_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes the same clock and reset as the serialiser.
`timescale 1ns/1ps
module tx_skid_buf #(
    parameter int W = 9
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    tx_word_if.dst in_if,
    tx_word_if.src out_if
);
    logic [W-1:0] mem_reg [2];
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;

    assign in_if.ready = (cnt_reg != 2'h2);
    assign push = in_if.valid && in_if.ready;
    assign pop = out_if.valid && out_if.ready;
    assign out_if.valid = (cnt_reg != 2'h0);
    assign out_if.data = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_if.data;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// file: rtl/serial_fifo_transmit_control.sv
// Transmit FIFO, serialiser and transmit interrupt control.
// Assumes every input is a software-side strobe or level synchronous to clk_i.
`timescale 1ns/1ps
//
// Operation
// RQ1: A byte written to the FIFO port is moved into the shift register and serialised.
// RQ2: Software writes at most sixteen minus the fill count bytes.
// RQ3: In async mode the start request fires when enable and irq enable rise in one write.
// RQ4: In sync mode the start request fires when enable rises with irq enable already or newly set.
// RQ5: With the FIFO empty the done flag sets, the stop bit is sent and the line idles high.
// RQ6: The end interrupt is raised when the done flag sets with its enable high.
// RQ7: For 9-bit characters software writes both the high and low ports.
// RQ8: Writing 0 clears the condition-complete flag and software reads it back.
// RQ9: Writing mode select 0 outside simple I2C clears the condition-complete flag.
// RQ10: Writing transmit enable 0 clears the condition-complete flag.
// RQ11: Before full duplex software confirms reception and clears receive enables.
// RQ12: Software checks overrun is 0 then sets all four enables in one write.
// RQ13: In snooze mode software sets doubling and base clock selects to 0.
// RQ14: Snooze bit rate stays within 2400, 600 or 1200 bps limits.
// RQ15: A five-bit fill count tracks writes and transfers and never passes sixteen.
module serial_fifo_transmit_control #(
    parameter int BAUD_DIV = sfc_pkg::BAUD_DIV_DEFAULT
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sync_mode_i,
    input wire logic nine_bit_i,
    input wire logic ctrl_wr_i,
    input wire logic tx_enable_bit_i,
    input wire logic tx_irq_enable_i,
    input wire logic tx_done_irq_enable_i,
    input wire logic low_wr_i,
    input wire logic [7:0] tx_fifo_low_write_port_i,
    input wire logic high_wr_i,
    input wire logic tx_fifo_high_write_port_i,
    input wire logic i2c_mode_wr_i,
    input wire logic i2c_mode_select_i,
    input wire logic i2c_active_i,
    input wire logic i2c_cond_set_i,
    input wire logic i2c_flag_wr0_i,
    output logic [4:0] tx_fifo_fill_count_o,
    output logic tx_done_flag_o,
    output logic tx_request_irq_o,
    output logic tx_end_irq_o,
    output logic i2c_cond_done_flag_o,
    output logic txd_o
);
    typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} tx_state_t;

    tx_state_t state_reg;
    logic te_reg;
    logic tie_reg;
    logic [4:0] count_reg;
    logic [sfc_pkg::CHAR_W-1:0] fifo_reg [sfc_pkg::FIFO_DEPTH];
    logic [3:0] wptr_reg;
    logic [3:0] rptr_reg;
    logic high_bit_reg;
    logic [sfc_pkg::CHAR_W-1:0] tx_shift_reg;
    logic [3:0] bit_reg;
    logic [15:0] baud_reg;
    logic baud_tick;
    logic push;
    logic pull;
    logic load;
    logic done_set;

    tx_word_if #(.W(sfc_pkg::CHAR_W)) fifo_out ();
    tx_word_if #(.W(sfc_pkg::CHAR_W)) buf_out ();

    tx_skid_buf #(.W(sfc_pkg::CHAR_W)) u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_if(fifo_out),
        .out_if(buf_out)
    );

    // Writes beyond sixteen entries are dropped
    assign push = low_wr_i && (count_reg != sfc_pkg::COUNT_FULL) && te_reg;
    assign fifo_out.valid = (count_reg != sfc_pkg::COUNT_RESET);
    assign fifo_out.data = fifo_reg[rptr_reg];
    assign pull = fifo_out.valid && fifo_out.ready;
    assign load = (state_reg == ST_IDLE || (state_reg == ST_STOP && baud_tick)) && buf_out.valid && te_reg;
    assign buf_out.ready = load;
    assign baud_tick = (baud_reg == 16'(BAUD_DIV - 1));
    assign done_set = state_reg == ST_STOP && baud_tick && !(buf_out.valid && te_reg);
    assign tx_fifo_fill_count_o = count_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            te_reg <= 1'b0;
            tie_reg <= 1'b0;
        end else if (ctrl_wr_i) begin
            te_reg <= tx_enable_bit_i;
            tie_reg <= tx_irq_enable_i;
        end
    end

    // RQ3 RQ4 start request
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) tx_request_irq_o <= 1'b0;
        else if (sync_mode_i) tx_request_irq_o <= ctrl_wr_i && tx_enable_bit_i && !te_reg
            && (tx_irq_enable_i || tie_reg);
        else tx_request_irq_o <= ctrl_wr_i && tx_enable_bit_i && tx_irq_enable_i && !te_reg && !tie_reg;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) high_bit_reg <= 1'b0;
        else if (high_wr_i) high_bit_reg <= tx_fifo_high_write_port_i;
    end

    // RQ15 fill count
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_reg <= sfc_pkg::COUNT_RESET;
            wptr_reg <= 4'h0;
            rptr_reg <= 4'h0;
        end else begin
            if (push) wptr_reg <= wptr_reg + 4'h1;
            if (pull) rptr_reg <= rptr_reg + 4'h1;
            count_reg <= count_reg + {4'h0, push} - {4'h0, pull};
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) fifo_reg[wptr_reg] <= {nine_bit_i && high_bit_reg, tx_fifo_low_write_port_i};
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) baud_reg <= 16'h0000;
        else if (state_reg == ST_IDLE || baud_tick) baud_reg <= 16'h0000;
        else baud_reg <= baud_reg + 16'h0001;
    end

    // RQ1 RQ5 serialiser
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            tx_shift_reg <= sfc_pkg::DATA_RESET;
            bit_reg <= sfc_pkg::BIT_RESET;
            txd_o <= 1'b1;
        end else if (load) begin
            tx_shift_reg <= buf_out.data;
            bit_reg <= sfc_pkg::BIT_RESET;
            state_reg <= ST_START;
            txd_o <= 1'b0;
        end else if (baud_tick) begin
            unique case (state_reg)
                ST_IDLE: txd_o <= 1'b1;
                ST_START, ST_DATA: begin
                    if (bit_reg == (nine_bit_i ? sfc_pkg::BITS_9 : sfc_pkg::BITS_8)) begin
                        state_reg <= ST_STOP;
                        txd_o <= 1'b1;
                    end else begin
                        state_reg <= ST_DATA;
                        txd_o <= tx_shift_reg[0];
                        tx_shift_reg <= tx_shift_reg >> 1;
                        bit_reg <= bit_reg + 4'h1;
                    end
                end
                ST_STOP: begin
                    state_reg <= ST_IDLE;
                    txd_o <= 1'b1;
                end
            endcase
        end
    end

    // RQ5 RQ6 done flag and end request
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_done_flag_o <= 1'b1;
            tx_end_irq_o <= 1'b0;
        end else begin
            tx_end_irq_o <= done_set && tx_done_irq_enable_i;
            if (done_set) tx_done_flag_o <= 1'b1;
            else if (load) tx_done_flag_o <= 1'b0;
        end
    end

    // RQ8 RQ9 RQ10 flag clears, set wins
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) i2c_cond_done_flag_o <= 1'b0;
        else if (i2c_cond_set_i) i2c_cond_done_flag_o <= 1'b1;
        else if (i2c_flag_wr0_i || (i2c_mode_wr_i && !i2c_mode_select_i && !i2c_active_i)
            || (ctrl_wr_i && !tx_enable_bit_i)) i2c_cond_done_flag_o <= 1'b0;
    end

    // RQ15 count bound
    fill_bound_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ15
        count_reg <= sfc_pkg::COUNT_FULL) else $error("fill count over sixteen");
    // RQ3 async start
    async_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ3
        !sync_mode_i && ctrl_wr_i && tx_enable_bit_i && tx_irq_enable_i && !te_reg && !tie_reg
        |=> tx_request_irq_o) else $error("async start request missing");
    // RQ4 sync start
    sync_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ4
        sync_mode_i && ctrl_wr_i && tx_enable_bit_i && !te_reg && tie_reg
        |=> tx_request_irq_o) else $error("sync start request missing");
    // RQ6 end request
    end_irq_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ6
        tx_end_irq_o |-> tx_done_flag_o) else $error("end irq without done flag");
    // RQ6 end on done
    end_on_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ6
        done_set && tx_done_irq_enable_i |=> tx_end_irq_o && tx_done_flag_o) else $error("end irq missing");
    // RQ5 idle line high
    idle_mark_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ5
        state_reg == ST_IDLE && $past(state_reg) == ST_IDLE |-> txd_o) else $error("idle line not high");
    // RQ10 clear on te write
    te_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ10
        ctrl_wr_i && !tx_enable_bit_i && !i2c_cond_set_i |=> !i2c_cond_done_flag_o)
        else $error("flag kept after te clear");
    // RQ8 write zero clear
    wr0_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ8
        i2c_flag_wr0_i && !i2c_cond_set_i |=> !i2c_cond_done_flag_o) else $error("flag kept after write 0");
    // RQ9 mode clear
    mode_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ9
        i2c_mode_wr_i && !i2c_mode_select_i && !i2c_active_i && !i2c_cond_set_i |=> !i2c_cond_done_flag_o)
        else $error("flag kept after mode write");
    // RQ1 load starts frame
    load_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ1
        load |=> state_reg == ST_START && !txd_o) else $error("load did not start frame");
endmodule

// file: verification/serial_peer_model.sv
// Line-side peer that decodes characters sent on the serial output.
// Assumes the same clock as the block and BAUD_DIV clocks per bit.
`timescale 1ns/1ps
module serial_peer_model #(
    parameter int BAUD_DIV = 4
) (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic nine_bit_i,
    output logic [8:0] char_o,
    output int count_o,
    output logic frame_err_o
);
    // start bit, data LSB first, stop bit at 1
    initial begin
        logic [8:0] sh;
        int n;
        count_o = 0;
        char_o = 9'h000;
        frame_err_o = 1'b0;
        forever begin
            @(negedge line_i);
            n = nine_bit_i ? 9 : 8;
            repeat (BAUD_DIV / 2) @(posedge clk_i);
            if (line_i === 1'b0) begin
                sh = 9'h000;
                for (int i = 0; i < n; i++) begin
                    repeat (BAUD_DIV) @(posedge clk_i);
                    sh[i] = line_i;
                end
                repeat (BAUD_DIV) @(posedge clk_i);
                if (line_i !== 1'b1) frame_err_o = 1'b1;
                char_o = sh;
                count_o++;
            end
        end
    end
endmodule

// file: verification/serial_fifo_transmit_control_tb.sv
// Self-checking bench for the transmit FIFO and its interrupt control.
// Assumes the peer model on the serial line and BAUD_DIV of 4.
`timescale 1ns/1ps
module serial_fifo_transmit_control_tb;
    localparam int BD = 4;
    typedef struct packed {logic nine; logic hb; logic [7:0] d; logic [8:0] exp;} row_t;
    row_t rows [5] = '{'{1'b0, 1'b0, 8'hA5, 9'h0A5}, '{1'b0, 1'b0, 8'h01, 9'h001},
        '{1'b1, 1'b1, 8'h3C, 9'h13C}, '{1'b1, 1'b0, 8'hFF, 9'h0FF}, '{1'b0, 1'b1, 8'h80, 9'h080}};
    logic clk_i = 1'b0, sys_rst_i = 1'b1, sync_mode_i = 1'b0, nine_bit_i = 1'b0, ctrl_wr_i = 1'b0;
    logic tx_enable_bit_i = 1'b0, tx_irq_enable_i = 1'b0, tx_done_irq_enable_i = 1'b1, low_wr_i = 1'b0;
    logic [7:0] tx_fifo_low_write_port_i = 8'h00;
    logic high_wr_i = 1'b0, tx_fifo_high_write_port_i = 1'b0, i2c_mode_wr_i = 1'b0, i2c_mode_select_i = 1'b0;
    logic i2c_active_i = 1'b0, i2c_cond_set_i = 1'b0, i2c_flag_wr0_i = 1'b0;
    logic [4:0] tx_fifo_fill_count_o;
    logic tx_done_flag_o, tx_request_irq_o, tx_end_irq_o, i2c_cond_done_flag_o, txd_o, frame_err;
    logic [8:0] rx_char;
    int rx_cnt, req_n = 0, end_n = 0, miscompares = 0, comparisons = 0, n0, e0, k;
    serial_fifo_transmit_control #(.BAUD_DIV(BD)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .sync_mode_i(sync_mode_i), .nine_bit_i(nine_bit_i), .ctrl_wr_i(ctrl_wr_i),
        .tx_enable_bit_i(tx_enable_bit_i), .tx_irq_enable_i(tx_irq_enable_i),
        .tx_done_irq_enable_i(tx_done_irq_enable_i), .low_wr_i(low_wr_i),
        .tx_fifo_low_write_port_i(tx_fifo_low_write_port_i), .high_wr_i(high_wr_i),
        .tx_fifo_high_write_port_i(tx_fifo_high_write_port_i), .i2c_mode_wr_i(i2c_mode_wr_i),
        .i2c_mode_select_i(i2c_mode_select_i), .i2c_active_i(i2c_active_i), .i2c_cond_set_i(i2c_cond_set_i),
        .i2c_flag_wr0_i(i2c_flag_wr0_i), .tx_fifo_fill_count_o(tx_fifo_fill_count_o),
        .tx_done_flag_o(tx_done_flag_o), .tx_request_irq_o(tx_request_irq_o), .tx_end_irq_o(tx_end_irq_o),
        .i2c_cond_done_flag_o(i2c_cond_done_flag_o), .txd_o(txd_o));
    serial_peer_model #(.BAUD_DIV(BD)) peer (.clk_i(clk_i), .line_i(txd_o), .nine_bit_i(nine_bit_i),
        .char_o(rx_char), .count_o(rx_cnt), .frame_err_o(frame_err));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (tx_request_irq_o === 1'b1) req_n++;
        if (tx_end_irq_o === 1'b1) end_n++;
    end
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // receiver and snooze selects stay off
    task automatic ctrl(input logic te, input logic tx_irq_enable);
        @(negedge clk_i);
        tx_enable_bit_i = te;
        tx_irq_enable_i = tx_irq_enable;
        ctrl_wr_i = 1'b1;
        @(negedge clk_i);
        ctrl_wr_i = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic irq_seq(input logic [1:0] a, input logic [1:0] b, input int exp);
        ctrl(1'b0, 1'b0);
        n0 = req_n;
        ctrl(a[1], a[0]);
        ctrl(b[1], b[0]);
        check("start request count", 9'(req_n - n0), 9'(exp));
    endtask
    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (19) @(negedge clk_i);
        check("reset state", {2'b00, tx_fifo_fill_count_o, tx_done_flag_o, txd_o}, 9'h003);
        check("reset irqs", {6'h00, tx_request_irq_o, tx_end_irq_o, i2c_cond_done_flag_o}, 9'h000);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        irq_seq(2'b00, 2'b11, 1);
        foreach (rows[i]) begin
            nine_bit_i = rows[i].nine;
            n0 = rx_cnt;
            e0 = end_n;
            tx_fifo_high_write_port_i = rows[i].hb;
            high_wr_i = 1'b1;
            @(negedge clk_i);
            high_wr_i = 1'b0;
            tx_fifo_low_write_port_i = rows[i].d;
            low_wr_i = 1'b1;
            @(negedge clk_i);
            low_wr_i = 1'b0;
            for (k = 0; k < 300 && rx_cnt == n0; k++) @(posedge clk_i);
            @(negedge clk_i);
            check("received char", rx_char, rows[i].exp);
            for (k = 0; k < 50 && tx_done_flag_o !== 1'b1; k++) @(posedge clk_i);
            repeat (2) @(negedge clk_i);
            check("done and idle", {7'h00, tx_done_flag_o, txd_o}, 9'h003);
            check("end irq count", 9'(end_n - e0), 9'h001);
        end
        nine_bit_i = 1'b0;
        irq_seq(2'b01, 2'b11, 0);
        irq_seq(2'b10, 2'b11, 0);
        sync_mode_i = 1'b1;
        irq_seq(2'b01, 2'b11, 1);
        irq_seq(2'b00, 2'b11, 1);
        sync_mode_i = 1'b0;
        for (int c = 0; c < 5; c++) begin
            i2c_cond_set_i = 1'b1;
            @(negedge clk_i);
            // Case 4 sets and clears in one cycle; the set wins
            i2c_cond_set_i = (c == 4);
            i2c_active_i = (c == 2);
            if (c == 0 || c == 4) i2c_flag_wr0_i = 1'b1;
            else if (c < 3) i2c_mode_wr_i = 1'b1;
            if (c == 3) ctrl(1'b0, 1'b0);
            else @(negedge clk_i);
            {i2c_cond_set_i, i2c_flag_wr0_i, i2c_mode_wr_i, i2c_active_i} = 4'h0;
            @(negedge clk_i);
            check("cond flag", {8'h00, i2c_cond_done_flag_o}, {8'h00, c == 2 || c == 4});
        end
        // Reset in mid-run clears the held flag and the count
        sys_rst_i = 1'b1;
        @(negedge clk_i);
        check("mid reset", {2'b00, tx_fifo_fill_count_o, tx_done_flag_o, i2c_cond_done_flag_o}, 9'h002);
        sys_rst_i = 1'b0;
        @(negedge clk_i);
        low_wr_i = 1'b1;
        @(negedge clk_i);
        low_wr_i = 1'b0;
        @(negedge clk_i);
        check("push with enable off", {4'h0, tx_fifo_fill_count_o}, 9'h000);
        tx_done_irq_enable_i = 1'b0;
        e0 = end_n;
        ctrl(1'b1, 1'b0);
        low_wr_i = 1'b1;
        repeat (20) @(negedge clk_i);
        low_wr_i = 1'b0;
        @(negedge clk_i);
        check("count at full", {4'h0, tx_fifo_fill_count_o}, {4'h0, sfc_pkg::COUNT_FULL});
        for (k = 0; k < 1500 && !(tx_done_flag_o === 1'b1 && tx_fifo_fill_count_o === 5'h00); k++) @(posedge clk_i);
        repeat (BD * 3) @(negedge clk_i);
        check("drained idle", {2'b00, tx_fifo_fill_count_o, tx_done_flag_o, txd_o}, 9'h003);
        check("framing", {8'h00, frame_err}, 9'h000);
        check("end irq while disabled", 9'(end_n - e0), 9'h000);
        print_verdict();
    end
endmodule
